// File: hw/agc_flag_regs.v
// agc debounce, adc flag and dac power registers with their control logic
`timescale 1ns/1ps
`include "agc_regs_map.vh"
module agc_flag_regs #(
   parameter STEP_CYCLES = `DEBOUNCE_STEP_CYCLES
) (
   // clock and reset
   input  wire       clock,
   input  wire       resetn,
   // decoded control bus access
   input  wire [6:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_write,
   input  wire       reg_read,
   output reg  [7:0] reg_rdata,
   // mode
   input  wire       double_rate_audio,
   // left record channel state
   input  wire [6:0] left_pga_programmed,
   input  wire [6:0] left_pga_applied,
   input  wire       left_adc_powered,
   input  wire [4:0] left_noise_threshold,
   input  wire       left_below_threshold,
   input  wire [7:0] left_agc_applied_gain,
   input  wire [6:0] left_agc_max_gain,
   // right record channel state
   input  wire [6:0] right_pga_programmed,
   input  wire [6:0] right_pga_applied,
   input  wire       right_adc_powered,
   input  wire [4:0] right_noise_threshold,
   input  wire       right_below_threshold,
   input  wire [7:0] right_agc_applied_gain,
   input  wire [6:0] right_agc_max_gain,
   // dac power and headphone common output
   output reg        left_dac_power,
   output reg        right_dac_power,
   output reg  [1:0] headphone_common_output
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg  [7:0]  left_agc_debounce;
   reg  [7:0]  right_agc_debounce;
   reg  [7:0]  adc_flags;
   reg  [16:0] step_count;
   reg         step_tick;
   reg  [7:0]  next_rdata;
   reg  [7:0]  next_flags;
   reg         next_left_dac;
   reg         next_right_dac;
   reg  [1:0]  next_hp_mode;
   wire [16:0] step_limit;
   wire [6:0]  left_max_eff;
   wire [6:0]  right_max_eff;
   wire        left_silence;
   wire        right_silence;
   wire        write_left_deb;
   wire        write_right_deb;
   wire        write_dac;

   // ----------------------------------------
   // half-millisecond step generator
   // ----------------------------------------
   // under double rate the audio clock runs twice as fast, so each
   // step is half as long and the programmed times shrink by half
   assign step_limit = double_rate_audio ? STEP_CYCLES[17:1] - 17'h00001 :
                                          STEP_CYCLES[16:0] - 17'h00001;

   always @(posedge clock) begin
      if (!resetn) begin
         step_count <= 17'h00000;
         step_tick  <= 1'b0;
      end else if (step_count >= step_limit) begin
         step_count <= 17'h00000;
         step_tick  <= 1'b1;
      end else begin
         step_count <= step_count + 17'h00001;
         step_tick  <= 1'b0;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   assign write_left_deb  = reg_write && (reg_addr == `OFS_LEFT_AGC_DEBOUNCE);
   assign write_right_deb = reg_write && (reg_addr == `OFS_RIGHT_AGC_DEBOUNCE);
   assign write_dac       = reg_write && (reg_addr == `OFS_DAC_POWER_OUTPUT_CONFIG);

   always @(posedge clock) begin
      if (!resetn) begin
         left_agc_debounce  <= `RST_AGC_DEBOUNCE;
         right_agc_debounce <= `RST_AGC_DEBOUNCE;
      end else begin
         if (write_left_deb) begin
            left_agc_debounce  <= reg_wdata;
         end
         if (write_right_deb) begin
            right_agc_debounce <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // dac power and headphone common output mode
   // ----------------------------------------
   // reserved low bits are not stored
   always @* begin
      next_left_dac  = left_dac_power;
      next_right_dac = right_dac_power;
      next_hp_mode   = headphone_common_output;
      if (write_dac) begin
         next_left_dac  = reg_wdata[`DAC_LEFT_POWER];
         next_right_dac = reg_wdata[`DAC_RIGHT_POWER];
         // the reserved code would leave the driver undefined, keep the old mode
         if (reg_wdata[`HP_COMMON_MSB:`HP_COMMON_LSB] != `HP_COMMON_RESERVED) begin
            next_hp_mode = reg_wdata[`HP_COMMON_MSB:`HP_COMMON_LSB];
         end
      end
   end

   always @(posedge clock) begin
      if (!resetn) begin
         left_dac_power          <= 1'b0;
         right_dac_power         <= 1'b0;
         headphone_common_output <= `RST_HP_COMMON_MODE;
      end else begin
         left_dac_power          <= next_left_dac;
         right_dac_power         <= next_right_dac;
         headphone_common_output <= next_hp_mode;
      end
   end

   // ----------------------------------------
   // signal detection debounce per channel
   // ----------------------------------------
   debounce_channel left_debounce (
      .clock           (clock),
      .resetn          (resetn),
      .step_tick       (step_tick),
      .detect_enable   (left_noise_threshold != 5'h00),
      .below_threshold (left_below_threshold),
      .noise_code      (left_agc_debounce[`NOISE_DEB_MSB:`NOISE_DEB_LSB]),
      .signal_code     (left_agc_debounce[`SIGNAL_DEB_MSB:`SIGNAL_DEB_LSB]),
      .silence         (left_silence)
   );

   debounce_channel right_debounce (
      .clock           (clock),
      .resetn          (resetn),
      .step_tick       (step_tick),
      .detect_enable   (right_noise_threshold != 5'h00),
      .below_threshold (right_below_threshold),
      .noise_code      (right_agc_debounce[`NOISE_DEB_MSB:`NOISE_DEB_LSB]),
      .signal_code     (right_agc_debounce[`SIGNAL_DEB_MSB:`SIGNAL_DEB_LSB]),
      .silence         (right_silence)
   );

   // ----------------------------------------
   // adc flag register
   // ----------------------------------------
   // maximum gain codes past the top step all mean the top step
   assign left_max_eff  = (left_agc_max_gain  > `AGC_GAIN_TOP) ? `AGC_GAIN_TOP :
                          left_agc_max_gain;
   assign right_max_eff = (right_agc_max_gain > `AGC_GAIN_TOP) ? `AGC_GAIN_TOP :
                          right_agc_max_gain;

   always @* begin
      next_flags = 8'h00;
      next_flags[`FLAG_LEFT_PGA]     = (left_pga_applied == left_pga_programmed);
      next_flags[`FLAG_LEFT_POWER]   = left_adc_powered;
      next_flags[`FLAG_LEFT_SIGNAL]  = left_silence;
      next_flags[`FLAG_LEFT_SAT]     = (left_agc_applied_gain == {1'b0, left_max_eff});
      next_flags[`FLAG_RIGHT_PGA]    = (right_pga_applied == right_pga_programmed);
      next_flags[`FLAG_RIGHT_POWER]  = right_adc_powered;
      next_flags[`FLAG_RIGHT_SIGNAL] = right_silence;
      next_flags[`FLAG_RIGHT_SAT]    = (right_agc_applied_gain == {1'b0, right_max_eff});
   end

   // refreshed every cycle; a read only samples it
   always @(posedge clock) begin
      if (!resetn) begin
         adc_flags <= 8'h00;
      end else begin
         adc_flags <= next_flags;
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `OFS_LEFT_AGC_DEBOUNCE: begin
            next_rdata = left_agc_debounce;
         end
         `OFS_RIGHT_AGC_DEBOUNCE: begin
            next_rdata = right_agc_debounce;
         end
         `OFS_ADC_FLAGS: begin
            next_rdata = adc_flags;
         end
         `OFS_DAC_POWER_OUTPUT_CONFIG: begin
            // low four bits always read zero whatever was written
            next_rdata = {left_dac_power, right_dac_power,
                          headphone_common_output, 4'h0};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always @(posedge clock) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule // agc_flag_regs

// File: hw/agc_regs_map.vh
// register offsets, field positions, reset values and timing for the agc flag block
`ifndef AGC_REGS_MAP_VH
`define AGC_REGS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_LEFT_AGC_DEBOUNCE        7'h22
`define OFS_RIGHT_AGC_DEBOUNCE       7'h23
`define OFS_ADC_FLAGS                7'h24
`define OFS_DAC_POWER_OUTPUT_CONFIG  7'h25

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_AGC_DEBOUNCE             8'h00
`define RST_DAC_POWER_OUTPUT_CONFIG  8'h00
`define RST_HP_COMMON_MODE           2'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define NOISE_DEB_MSB                7
`define NOISE_DEB_LSB                3
`define SIGNAL_DEB_MSB               2
`define SIGNAL_DEB_LSB               0
`define FLAG_LEFT_PGA                7
`define FLAG_LEFT_POWER              6
`define FLAG_LEFT_SIGNAL             5
`define FLAG_LEFT_SAT                4
`define FLAG_RIGHT_PGA               3
`define FLAG_RIGHT_POWER             2
`define FLAG_RIGHT_SIGNAL            1
`define FLAG_RIGHT_SAT               0
`define DAC_LEFT_POWER               7
`define DAC_RIGHT_POWER              6
`define HP_COMMON_MSB                5
`define HP_COMMON_LSB                4
`define HP_COMMON_RESERVED           2'h3
`define AGC_GAIN_TOP                 7'h77

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_PERIOD_NS              4
`define DEBOUNCE_STEP_NS             500000
`define DEBOUNCE_STEP_CYCLES         (`DEBOUNCE_STEP_NS / `CLOCK_PERIOD_NS)

`endif

// File: hw/debounce_channel.v
// one channel of agc noise and signal detection debounce
`timescale 1ns/1ps
module debounce_channel (
   // clock and reset
   input  wire       clock,
   input  wire       resetn,
   // time base
   input  wire       step_tick,
   // detection inputs
   input  wire       detect_enable,
   input  wire       below_threshold,
   // debounce codes
   input  wire [4:0] noise_code,
   input  wire [2:0] signal_code,
   // debounced status
   output reg        silence
);

   reg  [11:0] count;
   wire [11:0] noise_steps;
   wire [11:0] signal_steps;
   wire [11:0] target;
   wire [11:0] count_inc;
   wire [4:0]  noise_over;

   // ----------------------------------------
   // code to half-millisecond steps
   // ----------------------------------------
   // codes 0..7 give 0,1,2,4..64 steps; above that 128 steps per code past 7
   assign noise_over   = noise_code - 5'h07;
   assign noise_steps  = (noise_code == 5'h00) ? 12'h000 :
                         (noise_code[4:3] == 2'h0) ?
                         (12'h001 << (noise_code[2:0] - 3'h1)) :
                         {noise_over, 7'h00};
   assign signal_steps = (signal_code == 3'h0) ? 12'h000 :
                         (12'h001 << (signal_code - 3'h1));
   assign target       = below_threshold ? noise_steps : signal_steps;
   assign count_inc    = count + 12'h001;

   // ----------------------------------------
   // debounce
   // ----------------------------------------
   always @(posedge clock) begin
      if (!resetn) begin
         count   <= 12'h000;
         silence <= 1'b0;
      end else if (!detect_enable) begin
         // detection off: status held clear
         count   <= 12'h000;
         silence <= 1'b0;
      end else if (below_threshold == silence) begin
         count   <= 12'h000;
      end else if (target == 12'h000) begin
         silence <= below_threshold;
         count   <= 12'h000;
      end else if (step_tick) begin
         if (count_inc >= target) begin
            silence <= below_threshold;
            count   <= 12'h000;
         end else begin
            count   <= count_inc;
         end
      end
   end

endmodule // debounce_channel

// File: sim/agc_flag_chk.sv
// assertion checker for the agc flag register block
`timescale 1ns/1ps
module agc_flag_chk (
   // clock and reset
   input       clock,
   input       resetn,
   // register strobes
   input [6:0] reg_addr,
   input [7:0] reg_wdata,
   input       reg_write,
   input       reg_read,
   input [7:0] reg_rdata,
   // left channel state
   input [6:0] left_pga_programmed,
   input [6:0] left_pga_applied,
   input       left_adc_powered,
   input [4:0] left_noise_threshold,
   input [7:0] left_agc_applied_gain,
   input [6:0] left_agc_max_gain,
   // outputs
   input       left_dac_power,
   input       right_dac_power,
   input [1:0] headphone_common_output
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // codes above the top act as the top, so clamp before comparing
   wire [7:0] sat_top = left_agc_max_gain > 7'h77 ? 8'h77 : {1'b0, left_agc_max_gain};
   wire       rd_flag = reg_read && reg_addr == 7'h24;
   wire       wr_dac  = reg_write && reg_addr == 7'h25;
   property p_dac; wr_dac |=>
      {left_dac_power, right_dac_power} == $past(reg_wdata[7:6]); endproperty
   a_dac: assert property (p_dac) else $error("dac power mismatch");
   property p_mode; wr_dac && reg_wdata[5:4] != 2'h3 |=>
      headphone_common_output == $past(reg_wdata[5:4]); endproperty
   a_mode: assert property (p_mode) else $error("output mode mismatch");
   property p_keep; wr_dac && reg_wdata[5:4] == 2'h3 |=> $stable(headphone_common_output);
   endproperty
   a_keep: assert property (p_keep) else $error("reserved mode taken");
   property p_low; reg_read && reg_addr == 7'h25 |=> reg_rdata[3:0] == 4'h0; endproperty
   a_low: assert property (p_low) else $error("reserved bits not zero");
   property p_pwr; rd_flag && $past(resetn) |=> reg_rdata[6] == $past(left_adc_powered, 2);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power flag mismatch");
   property p_pga; rd_flag && $past(resetn) |=>
      reg_rdata[7] == ($past(left_pga_applied, 2) == $past(left_pga_programmed, 2)); endproperty
   a_pga: assert property (p_pga) else $error("pga flag mismatch");
   property p_sat; rd_flag && $past(resetn) |=>
      reg_rdata[4] == ($past(left_agc_applied_gain, 2) == $past(sat_top, 2)); endproperty
   a_sat: assert property (p_sat) else $error("saturation flag mismatch");
   property p_quiet; rd_flag && $past(left_noise_threshold, 3) == 5'h00 |=> !reg_rdata[5];
   endproperty
   a_quiet: assert property (p_quiet) else $error("silence while disabled");
endmodule // agc_flag_chk
bind agc_flag_regs agc_flag_chk chk_u (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .left_pga_programmed, .left_pga_applied, .left_adc_powered,
   .left_noise_threshold, .left_agc_applied_gain, .left_agc_max_gain, .left_dac_power,
   .right_dac_power, .headphone_common_output);

// File: sim/agc_host_model.sv
// host controller model driving the decoded register strobes
`timescale 1ns/1ps
module agc_host_model (
   // clock
   input  wire       clock,
   // register strobes
   output reg  [6:0] reg_addr = 7'h00,
   output reg  [7:0] reg_wdata = 8'h00,
   output reg        reg_write = 1'b0,
   output reg        reg_read = 1'b0,
   input  wire [7:0] reg_rdata
);
   // rude lets a scenario break the host's side on purpose
   reg rude = 1'b0;
   task wr(input [6:0] a, input [7:0] d);
      if (!rude && a == 7'h25) d[3:0] = 4'h0;
      if (!rude && a == 7'h25 && d[5:4] == 2'h3) d[5:4] = 2'h0;
      @(posedge clock);
      {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
      @(posedge clock);
      {reg_addr, reg_wdata, reg_write} <= {~a, ~d, 1'b0};
      #1;
   endtask
   task rd(input [6:0] a, output [7:0] d);
      @(posedge clock);
      {reg_addr, reg_read} <= {a, 1'b1};
      @(posedge clock);
      {reg_addr, reg_read} <= {~a, 1'b0};
      #1 d = reg_rdata;
   endtask
endmodule // agc_host_model

// File: sim/agc_flag_regs_bench.sv
// self-checking bench for the agc flag register block
`timescale 1ns/1ps
module agc_flag_regs_bench;
   localparam S = 8;
   logic       clock, resetn = 0, double_rate_audio = 0;
   logic       left_adc_powered = 0, right_adc_powered = 0;
   logic       left_below_threshold = 0, right_below_threshold = 0;
   logic [4:0] left_noise_threshold = 0, right_noise_threshold = 0;
   logic [6:0] left_pga_programmed = 0, left_pga_applied = 0, left_agc_max_gain = 0;
   logic [6:0] right_pga_programmed = 0, right_pga_applied = 0, right_agc_max_gain = 0;
   logic [7:0] left_agc_applied_gain = 0, right_agc_applied_gain = 0;
   logic [7:0] reg_wdata, reg_rdata, v, mdl [34:37];
   logic [6:0] reg_addr, a;
   logic       reg_write, reg_read, left_dac_power, right_dac_power;
   logic [1:0] headphone_common_output;
   int         failures = 0, n_compared = 0, i;
   agc_flag_regs #(.STEP_CYCLES(S)) dut_u (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .double_rate_audio, .left_pga_programmed, .left_pga_applied,
      .left_adc_powered, .left_noise_threshold, .left_below_threshold, .left_agc_applied_gain,
      .left_agc_max_gain, .right_pga_programmed, .right_pga_applied, .right_adc_powered,
      .right_noise_threshold, .right_below_threshold, .right_agc_applied_gain,
      .right_agc_max_gain, .left_dac_power, .right_dac_power, .headphone_common_output);
   agc_host_model host_u (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   // ------------------------------------------
   // model and helpers
   // ------------------------------------------
   task chk(input string nm, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] top(input logic [6:0] m);
      return m > 7'h77 ? 8'h77 : {1'b0, m};
   endfunction
   function automatic logic [7:0] fl(input logic ls, rs);
      return {left_pga_applied == left_pga_programmed, left_adc_powered, ls,
         left_agc_applied_gain == top(left_agc_max_gain), right_pga_applied ==
         right_pga_programmed, right_adc_powered, rs, right_agc_applied_gain ==
         top(right_agc_max_gain)};
   endfunction
   task wr(input [6:0] ad, input [7:0] d);
      host_u.wr(ad, d);
      if (ad == 7'h22 || ad == 7'h23) mdl[ad] = d;
      if (ad == 7'h25) mdl[37] = {d[7:6], d[5:4] == 2'h3 ? mdl[37][5:4] : d[5:4], 4'h0};
   endtask
   task rdc(input [6:0] ad, input [7:0] exp);
      host_u.rd(ad, v);
      chk("read data", v, exp);
   endtask
   task deb(input int nc, sc, dr);
      int n, nn, ns, st;
      nn = nc < 8 ? (nc == 0 ? 0 : 1 << (nc - 1)) : 128 * (nc - 7);
      ns = sc == 0 ? 0 : 1 << (sc - 1);
      st = dr ? S / 2 : S;
      wr(7'h22, {nc[4:0], sc[2:0]});
      wr(7'h23, {nc[4:0], sc[2:0]});
      @(posedge clock);
      double_rate_audio <= dr[0];
      for (int ph = 0; ph < 2; ph++) begin
         n = ph ? ns : nn;
         @(posedge clock);
         {left_below_threshold, right_below_threshold} <= ph ? 2'b00 : 2'b11;
         if (n > 1) begin
            repeat ((n - 1) * st - 4) @(posedge clock);
            rdc(7'h24, fl(ph, ph));
         end
         repeat (st + 6) @(posedge clock);
         rdc(7'h24, fl(!ph, !ph));
      end
   endtask
   task summarize;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      summarize;
   end
   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   initial begin
      i = $urandom(73603);
      for (i = 34; i < 38; i++) mdl[i] = 8'h00;
      repeat (8) @(posedge clock);
      resetn <= 1;
      chk("dac out", {left_dac_power, right_dac_power, headphone_common_output}, 0);
      for (i = 0; i < 24; i++) begin
         a = 7'h22 + i % 4;
         v = $urandom;
         if (a == 7'h25) v = {v[7:6], 2'(i % 3), 4'h0};
         wr(a, v);
         chk("dac out", {left_dac_power, right_dac_power, headphone_common_output},
            {4'h0, mdl[37][7:4]});
         rdc(a, a == 7'h24 ? fl(0, 0) : mdl[a]);
      end
      host_u.rude = 1'b1;
      wr(7'h25, 8'hff);
      rdc(7'h25, mdl[37]);
      wr(7'h40, 8'h5a);
      rdc(7'h40, 8'h00);
      host_u.rude = 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         v = $urandom;
         {left_adc_powered, right_adc_powered, left_below_threshold, right_below_threshold} <= v;
         {left_pga_programmed, left_pga_applied} <= {5'h0, v[5:4], 5'h0, v[7:6]};
         {right_pga_programmed, right_pga_applied} <= {5'h0, v[1:0], 5'h0, v[3:2]};
         v = $urandom;
         left_agc_max_gain <= v[6:0];
         left_agc_applied_gain <= v[7] ? top(v[6:0]) : 8'($urandom);
         v = $urandom;
         right_agc_max_gain <= v[6:0];
         right_agc_applied_gain <= v[7] ? top(v[6:0]) : 8'($urandom);
         repeat (2) @(posedge clock);
         rdc(7'h24, fl(0, 0));
      end
      @(posedge clock);
      {left_below_threshold, right_below_threshold} <= 2'b00;
      {left_noise_threshold, right_noise_threshold} <= {5'h04, 5'h04};
      deb(0, 0, 0);
      deb(3, 7, 0);
      deb(8, 2, 0);
      deb(3, 1, 1);
      summarize;
   end
endmodule // agc_flag_regs_bench
